// file: core/synth_prog_pkg.sv
/*
 * Constants and types of the serial programming front end of a frequency synthesizer.
 * Assumes a 10 MHz core clock and a controller that makes the serial shift clock.
 */
// How it works
// - each rising shift clock edge moves the serial data level into the chain
// - counter values and control bit all arrive through the one serial data input
// - the last bit shifted before transfer becomes the one-bit control register
// - control one with enable high loads the 14-bit reference latch
// - control zero leaves the reference latch unchanged while enable is high
// - enable high always loads the divide-by-A and divide-by-N latch
// - divide-by-N, divide-by-A and control latches stay transparent while enable is high, following the chain
// - enable low holds every programming latch whatever data and clock do
// - divide-by-N and divide-by-A counters advance on rising prescaler input edges
// - innermost chain bit appears unlatched and non-inverted on the chain output
package synth_prog_pkg;
	localparam int CHAIN_W = 32;
	localparam int REF_W = 14;
	localparam int DIVN_W = 10;
	localparam int DIVA_W = 7;
	// field positions in the chain, oldest bit at the top
	localparam int REF_LSB = 18;
	localparam int DIVN_LSB = 8;
	localparam int DIVA_LSB = 1;
	localparam int CTRL_POS = 0;
	localparam logic [CHAIN_W-1:0] CHAIN_RST = 32'h0000_0000;
	localparam logic [REF_W-1:0] REF_RST = 14'h0000;
	localparam logic [DIVN_W-1:0] DIVN_RST = 10'h000;
	localparam logic [DIVA_W-1:0] DIVA_RST = 7'h00;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic [REF_W-1:0] ref_val;
		logic [DIVN_W-1:0] divn_val;
		logic [DIVA_W-1:0] diva_val;
		logic ctrl;
	} prog_word_t;

	typedef enum logic {
		MOD_LOW,
		MOD_HIGH
	} mod_phase_t;
endpackage

// file: core/synth_serial_program_latch.sv
/*
 * Serial programming chain, enable latches and prescaler-driven divide counters.
 * Assumes the controller keeps the chain still while enable is high long enough
 * for the core clock to see two equal samples, and a prescaler input slower than
 * half the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module synth_serial_program_latch (
	input wire logic i_core_clk, // 10 MHz core clock
	input wire logic i_resetn, // asynchronous reset, active low
	input wire logic i_shift_clk, // serial shift clock from controller
	input wire logic i_ser_data, // serial data, sampled on shift clock
	input wire logic i_latch_en, // transparent latch enable pin
	input wire logic i_presc_in, // prescaled frequency input
	output logic o_shift_chain_out, // innermost chain bit
	output logic [synth_prog_pkg::REF_W-1:0] o_ref_latch, // reference latch
	output logic [synth_prog_pkg::DIVN_W-1:0] o_divn_latch, // divide-by-N latch
	output logic [synth_prog_pkg::DIVA_W-1:0] o_diva_latch, // divide-by-A latch
	output logic o_ctrl_bit, // control register
	output logic o_mod_ctrl // modulus control, high in second phase
);
	// ==========================================================
	// link domain: shift chain
	logic [synth_prog_pkg::CHAIN_W-1:0] chain_reg;

	always_ff @(posedge i_shift_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			chain_reg <= synth_prog_pkg::CHAIN_RST;
		end else begin
			chain_reg <= {chain_reg[synth_prog_pkg::CHAIN_W-2:0], i_ser_data};
		end
	end

	assign o_shift_chain_out = chain_reg[synth_prog_pkg::CHAIN_W-1];

	AST_SHIFT_IN: assert property (@(posedge i_shift_clk) disable iff (!i_resetn)
		1'b1 |=> chain_reg[0] == $past(i_ser_data) &&
			chain_reg[synth_prog_pkg::CHAIN_W-1:1] ==
			$past(chain_reg[synth_prog_pkg::CHAIN_W-2:0]))
		else $error("chain did not shift in the data bit");

	AST_CHAIN_OUT: assert property (@(posedge i_shift_clk) disable iff (!i_resetn)
		1'b1 |=> o_shift_chain_out == $past(chain_reg[synth_prog_pkg::CHAIN_W-2]))
		else $error("chain output is not the innermost bit");

	// ==========================================================
	// crossing into the core domain
	logic en_meta_reg;
	logic en_sync_reg;
	logic [synth_prog_pkg::CHAIN_W-1:0] word_meta_reg;
	logic [synth_prog_pkg::CHAIN_W-1:0] word_sync_reg;
	logic [synth_prog_pkg::CHAIN_W-1:0] word_prev_reg;
	logic fin_meta_reg;
	logic fin_sync_reg;
	logic fin_prev_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			en_meta_reg <= 1'b0;
			en_sync_reg <= 1'b0;
		end else begin
			en_meta_reg <= i_latch_en;
			en_sync_reg <= en_meta_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			word_meta_reg <= synth_prog_pkg::CHAIN_RST;
			word_sync_reg <= synth_prog_pkg::CHAIN_RST;
			word_prev_reg <= synth_prog_pkg::CHAIN_RST;
		end else begin
			word_meta_reg <= chain_reg;
			word_sync_reg <= word_meta_reg;
			word_prev_reg <= word_sync_reg;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fin_meta_reg <= 1'b0;
			fin_sync_reg <= 1'b0;
			fin_prev_reg <= 1'b0;
		end else begin
			fin_meta_reg <= i_presc_in;
			fin_sync_reg <= fin_meta_reg;
			fin_prev_reg <= fin_sync_reg;
		end
	end

	// ==========================================================
	// transparent programming latches
	synth_prog_pkg::prog_word_t word;
	logic load;

	assign word = synth_prog_pkg::prog_word_t'(word_sync_reg);
	// only a word seen equal on two samples is taken, so a half-moved bus never lands
	assign load = en_sync_reg && (word_sync_reg == word_prev_reg);

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ctrl_bit <= 1'b0;
		end else if (load) begin
			o_ctrl_bit <= word.ctrl;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ref_latch <= synth_prog_pkg::REF_RST;
		end else if (load && word.ctrl) begin
			o_ref_latch <= word.ref_val;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_divn_latch <= synth_prog_pkg::DIVN_RST;
			o_diva_latch <= synth_prog_pkg::DIVA_RST;
		end else if (load) begin
			o_divn_latch <= word.divn_val;
			o_diva_latch <= word.diva_val;
		end
	end

	sequence s_word_settled;
		en_sync_reg && $stable(word_sync_reg) ##1 en_sync_reg && $stable(word_sync_reg);
	endsequence

	AST_CTRL_LAST: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		load |=> o_ctrl_bit == $past(word_sync_reg[synth_prog_pkg::CTRL_POS]))
		else $error("control bit is not the last shifted bit");

	AST_REF_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		load && word.ctrl |=> o_ref_latch ==
			$past(word_sync_reg[synth_prog_pkg::REF_LSB +: synth_prog_pkg::REF_W]))
		else $error("reference latch missed a load");

	AST_REF_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!(load && word.ctrl) |=> $stable(o_ref_latch))
		else $error("reference latch moved with control bit zero");

	AST_DIV_LOAD: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		load |=> o_divn_latch ==
			$past(word_sync_reg[synth_prog_pkg::DIVN_LSB +: synth_prog_pkg::DIVN_W]) &&
			o_diva_latch ==
			$past(word_sync_reg[synth_prog_pkg::DIVA_LSB +: synth_prog_pkg::DIVA_W]))
		else $error("divide latch missed a load");

	AST_TRANSPARENT: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		s_word_settled |=> o_divn_latch == $past(word.divn_val, 1))
		else $error("divide latch not following chain while enabled");

	AST_HOLD_LOW: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!en_sync_reg |=> $stable(o_divn_latch) && $stable(o_diva_latch) &&
			$stable(o_ref_latch) && $stable(o_ctrl_bit))
		else $error("latches changed while enable low");

	// ==========================================================
	// divide-by-N and divide-by-A counters
	logic [synth_prog_pkg::DIVN_W-1:0] n_cnt_reg;
	logic [synth_prog_pkg::DIVA_W-1:0] a_cnt_reg;
	synth_prog_pkg::mod_phase_t phase_reg;
	logic fin_rise;

	assign fin_rise = fin_sync_reg && !fin_prev_reg;

	// a count of one or less ends the cycle, so both counters reload on the next edge
	function automatic logic count_end(input logic [synth_prog_pkg::DIVN_W-1:0] n);
		return n <= 10'h001;
	endfunction

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			n_cnt_reg <= synth_prog_pkg::DIVN_RST;
			a_cnt_reg <= synth_prog_pkg::DIVA_RST;
		end else if (fin_rise) begin
			if (count_end(n_cnt_reg)) begin
				n_cnt_reg <= o_divn_latch;
				a_cnt_reg <= o_diva_latch;
			end else begin
				n_cnt_reg <= n_cnt_reg - 10'h001;
				if (a_cnt_reg != 7'h00) begin
					a_cnt_reg <= a_cnt_reg - 7'h01;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_reg <= synth_prog_pkg::MOD_LOW;
		end else begin
			case (phase_reg)
				synth_prog_pkg::MOD_LOW: begin
					if (a_cnt_reg == 7'h00 && !count_end(n_cnt_reg)) begin
						phase_reg <= synth_prog_pkg::MOD_HIGH;
					end
				end
				synth_prog_pkg::MOD_HIGH: begin
					if (fin_rise && count_end(n_cnt_reg)) begin
						phase_reg <= synth_prog_pkg::MOD_LOW;
					end
				end
				default: begin
					phase_reg <= synth_prog_pkg::MOD_LOW;
				end
			endcase
		end
	end

	assign o_mod_ctrl = (phase_reg == synth_prog_pkg::MOD_HIGH);

	AST_COUNT_STEP: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		fin_rise && !count_end(n_cnt_reg) |=> n_cnt_reg == $past(n_cnt_reg) - 10'h001)
		else $error("divide-by-N did not step on prescaler edge");

	AST_COUNT_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!fin_rise |=> $stable(n_cnt_reg) && $stable(a_cnt_reg))
		else $error("counters moved without a prescaler edge");
endmodule
`default_nettype wire

// file: verification/ctrl_model.sv
/*
 * Controller model: shifts whole words into the programming chain and drives enable.
 * Assumes the bench calls its tasks and leaves the core clock time to load.
 */
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	output logic o_shift_clk, // serial shift clock, still between words
	output logic o_ser_data, // serial data
	output logic o_latch_en // latch enable
);
	initial begin
		o_shift_clk = 1'b0;
		o_ser_data = 1'b0;
		o_latch_en = 1'b0;
	end
	// oldest bit first, control bit last, enable low throughout
	task automatic shift_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			o_ser_data = w[i];
			#32 o_shift_clk = 1'b1;
			#16 o_ser_data = ~w[i];
			#16 o_shift_clk = 1'b0;
		end
	endtask
	// only raised after the last shift edge
	task automatic set_en(input logic v);
		o_latch_en = v;
	endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
/*
 * Self-checking bench of the serial programming latch.
 * Assumes the controller model drives the link side at a 64 ns shift period.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_core_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_presc_in = 1'b0;
	wire logic sclk;
	wire logic sdat;
	wire logic len;
	logic chain, ctl, modc;
	logic [synth_prog_pkg::REF_W-1:0] refl;
	logic [synth_prog_pkg::DIVN_W-1:0] nl;
	logic [synth_prog_pkg::DIVA_W-1:0] al;
	logic [67:0] exp_q[$];
	logic [67:0] m;
	logic [31:0] last = 32'h0000_0000;
	logic [31:0] e_w = 32'h0000_0000;
	logic [31:0] r;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	event smp;
	ctrl_model u_ctrl (.o_shift_clk(sclk), .o_ser_data(sdat), .o_latch_en(len));
	synth_serial_program_latch u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_shift_clk(sclk), .i_ser_data(sdat), .i_latch_en(len), .i_presc_in(i_presc_in),
		.o_shift_chain_out(chain), .o_ref_latch(refl), .o_divn_latch(nl),
		.o_diva_latch(al), .o_ctrl_bit(ctl), .o_mod_ctrl(modc));
	always #50 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 1000) begin
			err_count++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: outputs %h expected %h", $time, got, exp);
		end
	endtask
	task automatic note(input logic [33:0] e, input logic [33:0] msk);
		@(negedge i_core_clk);
		exp_q.push_back({msk, e});
		->smp;
	endtask
	// watcher: oldest note against what the outputs show now
	always begin
		@(smp);
		m = exp_q.pop_front();
		check({refl, nl, al, ctl, modc, chain} & m[67:34], m[33:0] & m[67:34]);
	end
	// shift a word; with ld, raise enable and look while it is still high
	task automatic prog(input logic [31:0] wd, input logic ld);
		u_ctrl.shift_word(wd);
		last = wd;
		if (ld) begin
			e_w[17:0] = wd[17:0];
			if (wd[0])
				e_w[31:18] = wd[31:18];
			u_ctrl.set_en(1'b1);
			repeat (8) @(negedge i_core_clk);
		end
		note({e_w, 1'b0, last[31]}, 34'h3_FFFF_FFFD);
		u_ctrl.set_en(1'b0);
		repeat (4) @(negedge i_core_clk);
	endtask
	initial begin
		void'($urandom(15365));
		repeat (12) @(posedge i_core_clk);
		#5 i_resetn = 1'b1;
		note(34'h0_0000_0000, 34'h3_FFFF_FFFF);
		r = $urandom;
		prog({r[31:1], 1'b1}, 1'b1);
		r = $urandom;
		prog({r[31:1], 1'b0}, 1'b1);
		r = $urandom;
		prog(r, 1'b0);
		// N of 5, A of 2, control zero
		prog(32'h0000_0504, 1'b1);
		for (int i = 1; i <= 6; i++) begin
			@(posedge i_core_clk);
			#5 i_presc_in = 1'b1;
			repeat (4) @(posedge i_core_clk);
			#5 i_presc_in = 1'b0;
			repeat (3) @(posedge i_core_clk);
			note({32'h0000_0000, (i >= 3 && i <= 5), 1'b0}, 34'h0_0000_0002);
		end
		conclude();
	end
endmodule
`default_nettype wire
